/* logic/stpd_top.sv */
// power-down control for a multi-channel serial line transceiver
//
// Operation
// (R1) powerdown: pump off, transmitters high impedance
// (R2) kill input low always forces powerdown
// (R3) hold and kill high: stay up always
// (R4) auto mode: down after 30 s quiet
// (R5) auto mode: any input edge wakes
// (R6) powerdown keeps inactivity timer expired
// (R7) kill release alone does not wake
// (R8) hold falling edge restarts 30 s timer
// (R9) transmitting resumes within 100 us
// (R10) monitor variant: gate receivers in manual down
// (R11) valid flag low after 30 us invalid
// (R12) valid flag high 1 us after valid
// (R13) valid flag works always, no power effect
// (R14) ready low in down, high on rail
// (R15) host ties both high for always-on
// (R16) host may drive both from valid flag
// (R17) monitor receiver output always active
// (R18) receivers stay on in automatic powerdown
// (R19) intervals counted on the system clock
`default_nettype none
module stpd_top #(
    parameter int unsigned INACT_CYC = stpd_pkg::INACT_CYC
) (
    // clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // host force inputs
    input wire logic i_hold_awake_in,
    input wire logic i_power_kill_n_in,
    // line-side logic inputs
    input wire logic [stpd_pkg::N_TX-1:0] i_tx_in,
    input wire logic [stpd_pkg::N_RX-1:0] i_rx_in,
    input wire logic [stpd_pkg::N_RX-1:0] i_rx_level_ok,
    input wire logic i_monitor_rx_in,
    input wire logic i_rail_good,
    // power and output controls
    output logic o_pump_en,
    output logic o_tx_oe,
    output logic o_rx_oe,
    output logic o_monitor_rx_out,
    output logic o_line_valid,
    output logic o_ready,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);
    // timer handshakes
    logic any_edge; // registered transition on any tx or rx input
    logic inact_done; // 30 s timer expired
    logic inv_done; // all receivers invalid long enough
    logic val_done; // a receiver valid long enough
    logic wake_done; // wake guard elapsed

    // decoded force modes
    logic manual_down; // kill input low
    logic forced_on; // both inputs high
    logic auto_mode; // hold low, kill high
    logic pwr_req; // power wanted this cycle
    logic hold_fall; // falling edge of hold input
    logic all_invalid;
    logic any_valid;

    // local names for the sequencer type and its codes
    typedef stpd_pkg::stpd_pwr_t stpd_pwr_t;
    localparam stpd_pwr_t PS_DOWN = stpd_pkg::PS_DOWN;
    localparam stpd_pwr_t PS_WAKE = stpd_pkg::PS_WAKE;
    localparam stpd_pwr_t PS_UP = stpd_pkg::PS_UP;

    // power state
    stpd_pwr_t state_r;
    stpd_pwr_t state_nxt;
    logic hold_prev_r;
    logic pump_r, pump_nxt;
    logic tx_oe_r, tx_oe_nxt;
    logic rx_oe_r, rx_oe_nxt;
    logic ready_r, ready_nxt;
    logic mon_r;
    logic valid_r, valid_nxt;

    // bus state
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    stpd_pwr_t unused_state;
    stpd_pkg::stpd_stat_t stat;

    // input transition detector over every tx and rx input
    stpd_edge_det #(
        .W(stpd_pkg::N_TX + stpd_pkg::N_RX)
    ) u_edge (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_data({i_tx_in, i_rx_in}),
        .o_any_edge(any_edge)
    );

    // mode decode; kill dominates hold
    always_comb begin
        manual_down = !i_power_kill_n_in; // [R2]
        forced_on = i_power_kill_n_in && i_hold_awake_in; // [R3]
        auto_mode = i_power_kill_n_in && !i_hold_awake_in;
        hold_fall = hold_prev_r && !i_hold_awake_in;
        all_invalid = ~|i_rx_level_ok;
        any_valid = |i_rx_level_ok;
        // a released kill with hold low only wakes once the timer is cleared
        pwr_req = forced_on || (auto_mode && !inact_done); // [R4] [R7]
    end

    // inactivity timer: edges and hold falling restart it, only the kill input pins it
    stpd_timer #(
        .CW(stpd_pkg::INACT_CW),
        .LIMIT(stpd_pkg::INACT_CW'(INACT_CYC))
    ) u_inact (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_clear(any_edge || hold_fall), // [R5] [R8]
        // an automatic powerdown already leaves the count saturated, so only the
        // kill input pins it; an edge must still be able to clear it in auto down
        .i_set(manual_down), // [R6]
        .i_run(auto_mode), // [R19]
        .o_done(inact_done)
    );

    // invalid-level persistence timer
    stpd_timer #(
        .CW(stpd_pkg::SHORT_CW),
        .LIMIT(stpd_pkg::SHORT_CW'(stpd_pkg::INVALID_CYC))
    ) u_invalid (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_clear(!all_invalid),
        .i_set(1'b0),
        .i_run(all_invalid), // [R11] [R19]
        .o_done(inv_done)
    );

    // valid-level qualification timer
    stpd_timer #(
        .CW(stpd_pkg::SHORT_CW),
        .LIMIT(stpd_pkg::SHORT_CW'(stpd_pkg::VALID_CYC))
    ) u_valid (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_clear(!any_valid),
        .i_set(1'b0),
        .i_run(any_valid), // [R12] [R19]
        .o_done(val_done)
    );

    // wake guard: bounds the wait for the rail so transmit resumes in time
    stpd_timer #(
        .CW(stpd_pkg::SHORT_CW),
        .LIMIT(stpd_pkg::SHORT_CW'(stpd_pkg::WAKE_CYC))
    ) u_wake (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_clear(state_r != PS_WAKE),
        .i_set(1'b0),
        .i_run(state_r == PS_WAKE), // [R9]
        .o_done(wake_done)
    );

    // power sequencer next state and output values
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PS_DOWN: begin
                if (pwr_req) begin
                    state_nxt = PS_WAKE;
                end
            end
            PS_WAKE: begin
                if (!pwr_req) begin
                    state_nxt = PS_DOWN; // [R1]
                end else if (i_rail_good || wake_done) begin
                    state_nxt = PS_UP; // [R9]
                end
            end
            PS_UP: begin
                if (!pwr_req) begin
                    state_nxt = PS_DOWN; // [R1]
                end
            end
            default: begin
                state_nxt = PS_DOWN; // the unused code falls back safe
            end
        endcase
        pump_nxt = (state_nxt != PS_DOWN); // [R1]
        tx_oe_nxt = (state_nxt == PS_UP); // [R1]
        // only a forced powerdown gates the standard receivers
        rx_oe_nxt = !(manual_down && ctrl_r[stpd_pkg::CTRL_RX_GATE_BIT]); // [R10] [R18]
        ready_nxt = (state_nxt != PS_DOWN) && i_rail_good; // [R14]
    end

    // line-valid flag; independent of the power state
    always_comb begin
        valid_nxt = valid_r;
        if (inv_done) begin
            valid_nxt = 1'b0; // [R11] [R13]
        end else if (val_done) begin
            valid_nxt = 1'b1; // [R12] [R13]
        end
    end

    // power registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= PS_DOWN;
            hold_prev_r <= 1'b0;
            pump_r <= 1'b0;
            tx_oe_r <= 1'b0;
            rx_oe_r <= 1'b1;
            ready_r <= 1'b0;
            mon_r <= 1'b0;
            valid_r <= 1'b0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            hold_prev_r <= i_hold_awake_in;
            pump_r <= pump_nxt;
            tx_oe_r <= tx_oe_nxt;
            rx_oe_r <= rx_oe_nxt;
            ready_r <= ready_nxt;
            mon_r <= i_monitor_rx_in; // [R17]
            valid_r <= valid_nxt;
        end
    end

    // status snapshot for software
    always_comb begin
        stat.auto_down = auto_mode && inact_done;
        stat.manual_down = manual_down;
        stat.expired = inact_done;
        stat.line_valid = valid_r;
        stat.ready = ready_r;
        stat.rx_oe = rx_oe_r;
        stat.tx_oe = tx_oe_r;
        stat.pump_en = pump_r;
        unused_state = state_r;
    end

    // apb slave: answers in the second access cycle, unmapped gives an error
    always_comb begin
        ctrl_nxt = ctrl_r;
        prdata_nxt = stpd_pkg::ZERO_WORD;
        pslverr_nxt = 1'b0;
        pready_nxt = i_psel && i_penable && !pready_r;
        if (i_psel && i_penable && !pready_r) begin
            if (i_paddr == stpd_pkg::OFS_STATUS) begin
                prdata_nxt = {24'h00_0000, stat};
            end else if (i_paddr == stpd_pkg::OFS_CTRL) begin
                prdata_nxt = {31'h0000_0000, ctrl_r[stpd_pkg::CTRL_RX_GATE_BIT]};
                if (i_pwrite) begin
                    ctrl_nxt = {31'h0000_0000, i_pwdata[stpd_pkg::CTRL_RX_GATE_BIT]};
                end
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    // bus registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= stpd_pkg::CTRL_RESET;
            prdata_r <= stpd_pkg::ZERO_WORD;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (i_ce) begin
            ctrl_r <= ctrl_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // outputs straight from flops
    assign o_pump_en = pump_r;
    assign o_tx_oe = tx_oe_r;
    assign o_rx_oe = rx_oe_r;
    assign o_monitor_rx_out = mon_r;
    assign o_line_valid = valid_r;
    assign o_ready = ready_r;
    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
endmodule
`default_nettype wire

/* logic/stpd_pkg.sv */
// package: constants and types for the transceiver power-down control
`default_nettype none
package stpd_pkg;
    // channel counts
    localparam int N_TX = 3;
    localparam int N_RX = 5;
    // timebase
    localparam longint CLK_HZ = 20_000_000;
    localparam longint US_PER_S = 1_000_000;
    // documented intervals, in their own units
    localparam longint INACT_S = 30;
    localparam longint INVALID_US = 30;
    localparam longint VALID_US = 1;
    localparam longint WAKE_US = 100;
    // derived cycle counts (exact at 20 mhz, so no rounding is lost)
    localparam int unsigned INACT_CYC = int'(INACT_S * CLK_HZ);
    localparam int unsigned INVALID_CYC = int'(INVALID_US * CLK_HZ / US_PER_S);
    localparam int unsigned VALID_CYC = int'(VALID_US * CLK_HZ / US_PER_S);
    localparam int unsigned WAKE_CYC = int'(WAKE_US * CLK_HZ / US_PER_S);
    // counter widths
    localparam int INACT_CW = 30;
    localparam int SHORT_CW = 12;
    // register map (byte addresses)
    localparam logic [31:0] OFS_STATUS = 32'h0000_0000;
    localparam logic [31:0] OFS_CTRL = 32'h0000_0004;
    // ctrl fields
    localparam int CTRL_RX_GATE_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // status field positions
    localparam int ST_PUMP_BIT = 0;
    localparam int ST_TXOE_BIT = 1;
    localparam int ST_RXOE_BIT = 2;
    localparam int ST_READY_BIT = 3;
    localparam int ST_VALID_BIT = 4;
    localparam int ST_EXPIRED_BIT = 5;
    localparam int ST_MANUAL_BIT = 6;
    localparam int ST_AUTO_BIT = 7;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // power sequencing states
    typedef enum logic [1:0] {
        PS_DOWN = 2'b00,
        PS_WAKE = 2'b01,
        PS_UP = 2'b10
    } stpd_pwr_t;
    // status word carried to the bus slave
    typedef struct packed {
        logic auto_down;
        logic manual_down;
        logic expired;
        logic line_valid;
        logic ready;
        logic rx_oe;
        logic tx_oe;
        logic pump_en;
    } stpd_stat_t;
endpackage
`default_nettype wire

/* logic/stpd_edge_det.sv */
// per-bit transition detector with a registered any-edge flag
`default_nettype none
module stpd_edge_det #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // sampled lines
    input wire logic [W-1:0] i_data,
    // any transition seen last cycle
    output logic o_any_edge
);
    logic [W-1:0] prev_r; // last sampled level per line
    logic [W-1:0] edge_bit; // per-line transition
    logic any_r;
    logic any_nxt;

    // one comparator per line
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            assign edge_bit[g] = i_data[g] ^ prev_r[g];
        end
    endgenerate

    // reduce to a single event
    always_comb begin
        any_nxt = |edge_bit;
    end

    // registers only; inputs are synchronous to the clock
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_r <= '0;
            any_r <= 1'b0;
        end else if (i_ce) begin
            prev_r <= i_data;
            any_r <= any_nxt;
        end
    end

    assign o_any_edge = any_r;
endmodule
`default_nettype wire

/* logic/stpd_timer.sv */
// saturating interval timer with clear and force-expire inputs
`default_nettype none
module stpd_timer #(
    parameter int CW = 12,
    parameter logic [CW-1:0] LIMIT = '1
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // control
    input wire logic i_clear,
    input wire logic i_set,
    input wire logic i_run,
    // status
    output logic o_done
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // set beats clear so a forced expiry cannot be undone the same cycle
    always_comb begin
        cnt_nxt = cnt_r;
        if (i_set) begin
            cnt_nxt = LIMIT;
        end else if (i_clear) begin
            cnt_nxt = '0;
        end else if (i_run && (cnt_r != LIMIT)) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // counter register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
        end else if (i_ce) begin
            cnt_r <= cnt_nxt;
        end
    end

    assign o_done = (cnt_r == LIMIT);
endmodule
`default_nettype wire

/* test/stpd_chk_sva.sv */
// assertion checker for the power-down control, bound to the top module
`default_nettype none
module stpd_chk #(
    parameter int unsigned INACT_CYC = stpd_pkg::INACT_CYC
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // inputs watched
    input wire logic i_hold_awake_in,
    input wire logic i_power_kill_n_in,
    input wire logic [stpd_pkg::N_TX-1:0] i_tx_in,
    input wire logic [stpd_pkg::N_RX-1:0] i_rx_in,
    input wire logic [stpd_pkg::N_RX-1:0] i_rx_level_ok,
    input wire logic i_monitor_rx_in,
    input wire logic i_rail_good,
    // outputs checked
    input wire logic o_pump_en,
    input wire logic o_tx_oe,
    input wire logic o_monitor_rx_out,
    input wire logic o_line_valid,
    input wire logic o_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LW = stpd_pkg::N_TX + stpd_pkg::N_RX;
    localparam int WK_MAX = stpd_pkg::WAKE_CYC + 2; // two cycles of register lag
    logic [11:0] wk_r, inv_r, val_r; // wake, invalid and valid run lengths
    logic [31:0] qt_r; // quiet cycles with the hold input low
    logic [LW-1:0] pv_r; // line inputs at the previous edge
    logic chg; // some line input moved
    assign chg = {i_tx_in, i_rx_in} != pv_r;
    // invalid and valid run lengths saturate so a long idle spell cannot wrap round
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {wk_r, inv_r, val_r, qt_r, pv_r} <= '0;
        end else begin
            pv_r <= {i_tx_in, i_rx_in};
            wk_r <= (o_pump_en && !o_tx_oe) ? wk_r + 12'h001 : '0;
            inv_r <= (i_rx_level_ok == '0) ? inv_r + 12'(inv_r != '1) : '0;
            val_r <= (i_rx_level_ok != '0) ? val_r + 12'(val_r != '1) : '0;
            qt_r <= (chg || i_hold_awake_in) ? '0 : qt_r + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    property p_kill;
        !i_power_kill_n_in |=> !o_pump_en && !o_tx_oe && !o_ready;
    endproperty
    a_kill: assert property (p_kill) else $error("kill low left power on");
    property p_down;
        !o_pump_en |-> !o_tx_oe;
    endproperty
    a_down: assert property (p_down) else $error("tx driven with pump off");
    property p_mon;
        $past(i_rst_n) |-> o_monitor_rx_out == $past(i_monitor_rx_in);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor output stalled");
    property p_ready;
        o_ready |-> $past(i_rail_good);
    endproperty
    a_ready: assert property (p_ready) else $error("ready without rail");
    property p_wake;
        wk_r <= WK_MAX;
    endproperty
    a_wake: assert property (p_wake) else $error("wake too slow");
    property p_hold;
        i_hold_awake_in && i_power_kill_n_in && o_tx_oe |=> o_tx_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("forced on dropped");
    property p_edge;
        chg && i_power_kill_n_in |-> ##[1:5] (o_pump_en || !i_power_kill_n_in);
    endproperty
    a_edge: assert property (p_edge) else $error("edge did not wake");
    property p_inv;
        $fell(o_line_valid) |-> inv_r >= stpd_pkg::INVALID_CYC;
    endproperty
    a_inv: assert property (p_inv) else $error("valid flag fell early");
    property p_val;
        $rose(o_line_valid) |-> val_r >= stpd_pkg::VALID_CYC;
    endproperty
    a_val: assert property (p_val) else $error("valid flag rose early");
    property p_auto;
        $fell(o_pump_en) && i_power_kill_n_in && $past(i_power_kill_n_in)
            |-> qt_r >= INACT_CYC - 2;
    endproperty
    a_auto: assert property (p_auto) else $error("auto down too soon");
endmodule
bind stpd_top stpd_chk #(.INACT_CYC(INACT_CYC)) chk_u (.*);
`default_nettype wire

/* test/stpd_host.sv */
// host power manager model driving the two force inputs
`default_nettype none
module stpd_host (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // scheme select, software kill, flag from the device
    input wire logic [1:0] i_mode,
    input wire logic i_sw_kill_n,
    input wire logic i_line_valid,
    // force pins
    output logic o_hold,
    output logic o_kill_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // a synchronous host: pins move only just after an edge
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hold <= 1'h1;
            o_kill_n <= 1'h1;
        end else if (i_mode == 2'h0) begin
            o_hold <= 1'h1; // always on: both strapped high
            o_kill_n <= 1'h1;
        end else if (i_mode == 2'h1) begin
            o_hold <= 1'h0; // software drives kill only
            o_kill_n <= i_sw_kill_n;
        end else begin
            o_hold <= i_line_valid; // flag routed to both pins
            o_kill_n <= i_line_valid;
        end
    end
endmodule
`default_nettype wire

/* test/tb_stpd_top.sv */
// self-checking testbench for the transceiver power-down control
`default_nettype none
module tb_stpd_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned INACT_CYC = 200; // shortened quiet interval
    logic i_sys_clk = 0, i_rst_n = 0, i_ce = 1, i_monitor_rx_in = 0, i_rail_good = 0;
    logic i_psel = 0, i_penable = 0, i_pwrite = 0, sw_kill_n = 1, err;
    logic [31:0] i_paddr = 0, i_pwdata = 0, rd, w;
    logic [2:0] i_tx_in = 0;
    logic [4:0] i_rx_in = 0, i_rx_level_ok = 5'h1f;
    logic [1:0] mode = 0;
    wire logic i_hold_awake_in, i_power_kill_n_in, o_pump_en, o_tx_oe, o_rx_oe;
    wire logic o_monitor_rx_out, o_line_valid, o_ready, o_pready, o_pslverr;
    wire logic [31:0] o_prdata;
    wire logic [2:0] obs = {o_tx_oe, o_line_valid, o_pump_en}; // waited-on flags
    int num_errors = 0, tests_run = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    stpd_top #(.INACT_CYC(INACT_CYC)) dut_u (.*);
    stpd_host host_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_mode(mode),
        .i_sw_kill_n(sw_kill_n), .i_line_valid(o_line_valid),
        .o_hold(i_hold_awake_in), .o_kill_n(i_power_kill_n_in));
    // verdict and end of run
    task automatic conclude();
        if (num_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // only bit 0 of the control word holds a value
    function automatic logic [31:0] exp_ctrl(input logic [31:0] d);
        return {31'h0000_0000, d[0]};
    endfunction
    // bounded wait for flag k to reach v; a run-out ends the test
    task automatic wsig(input int k, input logic v, input int lim);
        int n;
        n = 0;
        tests_run++;
        while (obs[k] !== v) begin
            @(posedge i_sys_clk);
            n++;
            if (n > lim) begin
                num_errors++;
                $display("unexpected at %0t: flag %0d stuck", $time, k);
                conclude();
            end
        end
    endtask
    // one apb transfer; the request is held until pready is sampled high
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge i_sys_clk);
        i_psel <= 1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            $display("unexpected at %0t: no pready", $time);
            conclude();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
    endtask
    initial begin
        void'($urandom(18));
        repeat (16) @(posedge i_sys_clk);
        i_rst_n <= 1;
        // register reset value, write/read back, unmapped place
        apb(0, stpd_pkg::OFS_CTRL, 0);
        chk(rd, stpd_pkg::CTRL_RESET);
        w = $urandom;
        apb(1, stpd_pkg::OFS_CTRL, w);
        apb(0, stpd_pkg::OFS_CTRL, 0);
        chk(rd, exp_ctrl(w));
        apb(1, 32'h0000_0010, w);
        chk(32'(err), 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1, stpd_pkg::OFS_CTRL, 32'h0000_0001);
        // forced on; rail held low so the 100 us fallback enables tx
        wsig(0, 1, 10);
        wsig(2, 1, 2010);
        chk(32'(o_ready), 0);
        i_rail_good <= 1;
        repeat (3) @(posedge i_sys_clk);
        chk(32'(o_ready), 1);
        apb(0, stpd_pkg::OFS_STATUS, 0);
        chk(32'(rd[3:0]), 32'h0000_000f);
        repeat (2 * INACT_CYC) @(posedge i_sys_clk);
        chk(32'(o_tx_oe), 1);
        // force-on falls: timer restarts, random edges keep it awake
        mode <= 1;
        repeat (INACT_CYC - 20) @(posedge i_sys_clk);
        chk(32'(o_pump_en), 1);
        i_tx_in <= ~i_tx_in; // first edge before the quiet interval runs out
        for (int i = 0; i < 8; i++) begin
            repeat ($urandom_range(150, 20)) @(posedge i_sys_clk);
            i_tx_in <= i_tx_in ^ 3'(1 + $urandom % 7);
        end
        repeat (INACT_CYC - 20) @(posedge i_sys_clk);
        chk(32'(o_pump_en), 1);
        wsig(0, 0, 30);
        chk(32'(o_rx_oe), 1);
        chk(32'(o_ready), 0);
        i_tx_in <= ~i_tx_in;
        wsig(0, 1, 6);
        // manual powerdown; edges meanwhile must not wake
        sw_kill_n <= 0;
        wsig(0, 0, 4);
        chk(32'(o_tx_oe), 0);
        chk(32'(o_rx_oe), 0);
        i_monitor_rx_in <= 1;
        i_rx_in <= 5'h15;
        repeat (10) @(posedge i_sys_clk);
        chk(32'(o_monitor_rx_out), 1);
        chk(32'(o_pump_en), 0);
        sw_kill_n <= 1;
        repeat (INACT_CYC + 50) @(posedge i_sys_clk);
        chk(32'(o_pump_en), 0);
        i_rx_in <= ~i_rx_in;
        wsig(0, 1, 6);
        // no-valid flag while forced on
        mode <= 0;
        i_rx_level_ok <= 0;
        repeat (590) @(posedge i_sys_clk);
        chk(32'(o_line_valid), 1);
        wsig(1, 0, 20);
        chk(32'(o_pump_en), 1);
        i_rx_level_ok <= 5'(1 << $urandom_range(4, 0));
        repeat (15) @(posedge i_sys_clk);
        chk(32'(o_line_valid), 0);
        wsig(1, 1, 12);
        // flag routed to both force pins
        mode <= 2;
        i_rx_level_ok <= 0;
        wsig(0, 0, 700);
        i_rx_level_ok <= 5'h02;
        wsig(0, 1, 40);
        conclude();
    end
endmodule
`default_nettype wire
